/* File: src/dpw_defs.vh */
// constants for the dual pot wiper serial control block
`ifndef DPW_DEFS_VH
`define DPW_DEFS_VH

// ****************************************************************
// command layout
// ****************************************************************
`define DPW_CMD_BITS      10
`define DPW_CODE_BITS     8
`define DPW_ADDR_MSB      9
`define DPW_ADDR_LSB      8
`define DPW_CODE_MSB      7
`define DPW_CODE_LSB      0

// ****************************************************************
// pot_address decode
// ****************************************************************
`define DPW_ADDR_A        2'h0
`define DPW_ADDR_B        2'h1
`define DPW_ADDR_NONE     2'h2
`define DPW_ADDR_BOTH     2'h3

// ****************************************************************
// reset values and bit counter width
// ****************************************************************
`define DPW_WIPER_RESET   8'h80
`define DPW_CNT_W         4

`endif

/* File: src/dpw_sync.v */
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module dpw_sync #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire sys_clk,
  input  wire arst_n,
  // level
  input  wire pin_in,
  output reg  pin_sync
);
  reg meta_reg;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meta_reg <= RESET_VAL;
      pin_sync <= RESET_VAL;
    end
    else
    begin
      meta_reg <= pin_in;
      pin_sync <= meta_reg;
    end
  end
endmodule // dpw_sync

/* File: src/dpw_wiper.v */
// one 8-bit wiper register with midscale reset
`timescale 1ns/1ps
`include "dpw_defs.vh"
module dpw_wiper #(
  parameter W = `DPW_CODE_BITS
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         arst_n,
  // load
  input  wire         load,
  input  wire [W-1:0] code,
  // tap select
  output reg  [W-1:0] position
);
  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      position <= `DPW_WIPER_RESET;       // [R07]
    else if (load)
      position <= code;                   // [R05] [R09]
  end
endmodule // dpw_wiper

/* File: src/dpw_ctrl.v */
// serial command receiver and wiper registers for a dual potentiometer
//
// Behaviour
// R01 - while select low, shift data in on each serial clock rise
// R02 - on select rise, last ten shifted bits form the command
// R03 - command order: two address bits msb first, then code msb first
// R04 - address 00 writes a, 01 writes b, 11 writes both
// R05 - a written wiper moves its tap at the select rise
// R06 - master holds select low whole frame; early rise ends it
// R07 - both wipers reset to midscale 80h
// R08 - code 00h is the low-end tap, ffh the high-end tap
// R09 - 256 taps, one code per tap, eight-bit register
// R10 - a write to one pot leaves the other untouched
// R11 - three inputs only, no readback output
// R12 - command reception never waits on charge pump settling
// R13 - address 10 is ignored, neither register changes
// R14 - frames with fewer than ten clock rises are discarded
`timescale 1ns/1ps
`include "dpw_defs.vh"
module dpw_ctrl #(
  parameter CMD_BITS  = `DPW_CMD_BITS,
  parameter CODE_BITS = `DPW_CODE_BITS
) (
  // system clock and reset
  input  wire                 sys_clk,
  input  wire                 arst_n,
  // serial pins, no data out [R11]
  input  wire                 chip_select_n,
  input  wire                 serial_clock_in,
  input  wire                 serial_data_in,
  // tap selections, 00h low end, ffh high end [R08]
  output wire [CODE_BITS-1:0] wiper_position_a,
  output wire [CODE_BITS-1:0] wiper_position_b
);

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wire cs_n_s;
  wire sck_s;
  wire din_s;

  dpw_sync #(.RESET_VAL(1'b1)) u_sync_cs (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pin_in   (chip_select_n),
    .pin_sync (cs_n_s)
  );

  dpw_sync #(.RESET_VAL(1'b0)) u_sync_sck (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pin_in   (serial_clock_in),
    .pin_sync (sck_s)
  );

  dpw_sync #(.RESET_VAL(1'b0)) u_sync_din (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .pin_in   (serial_data_in),
    .pin_sync (din_s)
  );

  // ****************************************************************
  // edge detection
  // ****************************************************************
  // data passes the same two stages as the clock, so it is sampled
  // at the clock rise as the master set it up; the sclk edge comes
  // from the second stage only
  reg  sck_d_reg;
  reg  cs_n_d_reg;
  wire sck_rise = sck_s & ~sck_d_reg;
  wire cs_rise  = cs_n_s & ~cs_n_d_reg;

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sck_d_reg  <= 1'b0;
      cs_n_d_reg <= 1'b1;
    end
    else
    begin
      sck_d_reg  <= sck_s;
      cs_n_d_reg <= cs_n_s;
    end
  end

  // ****************************************************************
  // shift register and bit count
  // ****************************************************************
  // nothing here looks at a charge pump state: bits are always
  // shifted in while select is low [R12]
  reg  [CMD_BITS-1:0]    shift_reg;
  reg  [CMD_BITS-1:0]    shift_next;
  reg  [`DPW_CNT_W-1:0]  count_reg;
  reg  [`DPW_CNT_W-1:0]  count_next;
  wire [`DPW_CNT_W-1:0]  full_cnt = CMD_BITS[`DPW_CNT_W-1:0];

  always @*
  begin
    shift_next = shift_reg;
    count_next = count_reg;
    if (cs_rise)
      count_next = {`DPW_CNT_W{1'b0}};
    else if (!cs_n_s && sck_rise)
    begin
      // only the last ten bits survive, first in ends up on top
      shift_next = {shift_reg[CMD_BITS-2:0], din_s};      // [R01] [R03]
      if (count_reg != full_cnt)
        count_next = count_reg + 1'b1;                    // saturates
    end
  end

  always @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shift_reg <= {CMD_BITS{1'b0}};
      count_reg <= {`DPW_CNT_W{1'b0}};
    end
    else
    begin
      shift_reg <= shift_next;
      count_reg <= count_next;
    end
  end

  // ****************************************************************
  // command decode at select rise
  // ****************************************************************
  // an early select rise ends the frame; short frames are dropped
  wire       frame_ok = cs_rise && (count_reg == full_cnt); // [R06] [R14]
  wire [1:0] pot_address =
    shift_reg[`DPW_ADDR_MSB:`DPW_ADDR_LSB];                 // [R02]
  wire [CODE_BITS-1:0] wiper_code =
    shift_reg[`DPW_CODE_MSB:`DPW_CODE_LSB];
  reg  load_a;
  reg  load_b;

  always @*
  begin
    load_a = 1'b0;
    load_b = 1'b0;
    if (frame_ok)
    begin
      case (pot_address)
        `DPW_ADDR_A:    load_a = 1'b1;                      // [R04] [R10]
        `DPW_ADDR_B:    load_b = 1'b1;                      // [R04] [R10]
        `DPW_ADDR_BOTH:
        begin
          load_a = 1'b1;                                    // [R04]
          load_b = 1'b1;
        end
        default:
        begin
          load_a = 1'b0;                                    // [R13]
          load_b = 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // wiper registers
  // ****************************************************************
  dpw_wiper #(.W(CODE_BITS)) u_wiper_a (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .load     (load_a),
    .code     (wiper_code),
    .position (wiper_position_a)
  );

  dpw_wiper #(.W(CODE_BITS)) u_wiper_b (
    .sys_clk  (sys_clk),
    .arst_n   (arst_n),
    .load     (load_b),
    .code     (wiper_code),
    .position (wiper_position_b)
  );

endmodule // dpw_ctrl

/* File: bench/dpw_ctrl_chk.sv */
// assertion checker for the wiper serial control
`timescale 1ns/1ps
module dpw_ctrl_chk #(parameter CMD_BITS = 10, CODE_BITS = 8) (
  // clock and reset
  input                 sys_clk,
  input                 arst_n,
  // select pin
  input                 chip_select_n,
  // wipers
  input [CODE_BITS-1:0] wiper_position_a,
  input [CODE_BITS-1:0] wiper_position_b
);
  wire       cs = chip_select_n;
  wire [7:0] wa = wiper_position_a;
  wire [7:0] wb = wiper_position_b;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ****
  // properties
  // ****
  property p_rst; $rose(arst_n) |-> wa == 8'h80 && wb == 8'h80; endproperty
  a_rst: assert property (p_rst) else $error("wiper not midscale");
  property p_low_a; !cs [*6] |-> $stable(wa); endproperty
  a_low_a: assert property (p_low_a) else $error("a moved in frame");
  property p_low_b; !cs [*6] |-> $stable(wb); endproperty
  a_low_b: assert property (p_low_b) else $error("b moved in frame");
  property p_late_a; cs [*8] |-> $stable(wa); endproperty
  a_late_a: assert property (p_late_a) else $error("a moved late");
  property p_late_b; cs [*8] |-> $stable(wb); endproperty
  a_late_b: assert property (p_late_b) else $error("b moved late");
  property p_why_a; $changed(wa) |-> $past(cs, 2); endproperty
  a_why_a: assert property (p_why_a) else $error("a moved early");
  property p_why_b; $changed(wb) |-> $past(cs, 2); endproperty
  a_why_b: assert property (p_why_b) else $error("b moved early");
  property p_both; $changed(wa) && $changed(wb) |-> wa == wb; endproperty
  a_both: assert property (p_both) else $error("dual write differs");
  c_a: cover property ($changed(wa));
  c_b: cover property ($changed(wb));
  c_ab: cover property ($changed(wa) && $changed(wb));
  c_rst: cover property ($rose(arst_n));
endmodule // dpw_ctrl_chk

bind dpw_ctrl dpw_ctrl_chk #(.CMD_BITS(CMD_BITS), .CODE_BITS(CODE_BITS))
  u_chk (.sys_clk, .arst_n, .chip_select_n, .wiper_position_a,
  .wiper_position_b);

/* File: bench/dpw_master.sv */
// serial bus master model for the wiper control pins
`timescale 1ns/1ps
module dpw_master (
  // clock
  input      clk,
  // serial pins
  output reg cs_n,
  output reg sck,
  output reg sdi
);
  initial {cs_n, sck, sdi} = 3'b100;
  task automatic send(input int n, input [15:0] w);
    int i;
    cs_n = 1'b0;
    for (i = n - 1; i >= 0; i--)
    begin
      sdi = w[i];
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      sck = 1'b0;
    end
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    // flip on release so a stale level is never trusted
    sdi = ~sdi;
    repeat (12) @(negedge clk);
  endtask
endmodule // dpw_master

/* File: bench/tb.sv */
// self-checking bench for the wiper serial control
`timescale 1ns/1ps
module tb;
  reg        sys_clk = 1'b0;
  reg        arst_n = 1'b0;
  wire       cs_n, sck, sdi;
  wire [7:0] wpa, wpb;
  int        err_total = 0;
  int        n_checks = 0;
  int        cyc = 0;
  initial forever #25 sys_clk = ~sys_clk;
  dpw_master m (.clk(sys_clk), .cs_n(cs_n), .sck(sck), .sdi(sdi));
  dpw_ctrl dut (.sys_clk(sys_clk), .arst_n(arst_n), .chip_select_n(cs_n),
    .serial_clock_in(sck), .serial_data_in(sdi),
    .wiper_position_a(wpa), .wiper_position_b(wpb));
  task chk(input [7:0] got, input [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input int n, input [15:0] w, input [7:0] ea, input [7:0] eb);
    m.send(n, w);
    chk(wpa, ea);
    chk(wpb, eb);
  endtask
  task results;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task t_reset;
    chk(wpa, 8'h80);
    chk(wpb, 8'h80);
  endtask
  task t_decode;
    wr(10, 16'h0000, 8'h00, 8'h80);
    wr(10, 16'h01ff, 8'h00, 8'hff);
    wr(10, 16'h0355, 8'h55, 8'h55);
  endtask
  task t_refuse;
    wr(10, 16'h02aa, 8'h55, 8'h55);
    wr(9, 16'h0000, 8'h55, 8'h55);
  endtask
  task t_long;
    wr(16, 16'hfd81, 8'h55, 8'h81);
  endtask
  // mid-run reset with both wipers away from midscale, then a
  // write four cycles after release to show reception restarts
  task t_rerun;
    arst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(wpa, 8'h80);
    chk(wpb, 8'h80);
    repeat (3) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(wpa, 8'h80);
    chk(wpb, 8'h80);
    wr(10, 16'h0342, 8'h42, 8'h42);
  endtask
  initial
  begin
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    t_reset;
    t_decode;
    t_refuse;
    t_long;
    t_rerun;
    results;
  end
  // whole run is near 730 cycles
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_total++;
      results;
    end
  end
endmodule // tb
